// File: tb/enc_sample_model.sv
// Encoder-side model sending one position sample per request
`timescale 1ns/100ps
module enc_sample_model
  import pos_cmp_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_go,
  input  wire logic signed [31:0] i_value,
  output pos_sample_s             o_pos
);
  pos_sample_s pos_r;
  pos_sample_s pos_nxt;

  assign o_pos = pos_r;

  always_comb begin
    pos_nxt.valid = i_go;
    // Value churns between samples so stale data never looks fresh
    pos_nxt.value = i_go ? i_value : ~pos_r.value;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pos_r <= '0;
    end else begin
      pos_r <= pos_nxt;
    end
  end
endmodule : enc_sample_model

// File: tb/tb.sv
// Self-checking testbench of the position compare channel
`timescale 1ns/100ps
`include "pos_cmp_map.svh"
module tb
  import pos_cmp_pkg::*;
;
  localparam logic signed [31:0] VA = 32'hFFFF_FFF6;
  localparam logic signed [31:0] VB = 32'h0000_0014;
  logic               clk      = 1'b0;
  logic               rst      = 1'b1;
  par_req_s           par      = '0;
  par_rsp_s           rsp;
  logic               go       = 1'b0;
  logic signed [31:0] go_value = '0;
  pos_sample_s        pos;
  logic               status;
  int                 err_count       = 0;
  int                 samples_checked = 0;
  logic signed [31:0] probe [5] = '{32'hFFFF_FFF5, 32'hFFFF_FFF6, 32'h0000_0005,
                                    32'h0000_0014, 32'h0000_0015};

  position_compare_channel #(.POS_W(32)) position_compare_channel_i (
    .i_clk    (clk),
    .i_rst    (rst),
    .i_par    (par),
    .o_par    (rsp),
    .i_pos    (pos),
    .o_status (status)
  );

  enc_sample_model enc_sample_model_i (
    .i_clk   (clk),
    .i_rst   (rst),
    .i_go    (go),
    .i_value (go_value),
    .o_pos   (pos)
  );

  initial begin
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  // Answer is registered on the same edge that takes the request
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic e, input logic [31:0] x);
    @(posedge clk);
    par <= '{w, !w, a, d};
    @(posedge clk);
    par <= '0;
    #1;
    check({30'h0, rsp.ack, rsp.err}, {30'h0, 1'b1, e});
    if (!w) begin
      check(rsp.rdata, x);
    end
  endtask : acc

  task automatic sample(input logic signed [31:0] v, input logic exp);
    @(posedge clk);
    go <= 1'b1;
    go_value <= v;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    check({31'h0, status}, {31'h0, exp});
  endtask : sample

  task automatic forced(input logic exp);
    @(posedge clk);
    #1;
    check({31'h0, status}, {31'h0, exp});
  endtask : forced

  function automatic logic hit(input int c, input logic signed [31:0] p, a, b);
    logic signed [31:0] lo;
    logic signed [31:0] hi;
    lo = (c >= 4 && b < a) ? b : a;
    hi = (c >= 4 && b < a) ? a : b;
    case (c)
      0: return p >= a;
      1: return p <= a;
      2, 4: return p >= lo && p <= hi;
      default: return p < lo || p > hi;
    endcase
  endfunction : hit

  ////////////////////////////////////////
  initial begin
    #500000;
    err_count++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    acc(0, `RUN_CTRL_ADDR, 0, 0, 0);
    acc(0, `CRIT_SEL_ADDR, 0, 0, 0);
    acc(0, `INPUT_SEL_ADDR, 0, 0, 0);
    acc(0, `THRESH_A_ADDR, 0, 0, 0);
    acc(0, `THRESH_B_ADDR, 0, 0, 0);
    acc(0, `CMP_STATUS_ADDR, 0, 0, 0);
    // Out-of-range values, read-only and unmapped places
    acc(1, `CRIT_SEL_ADDR, 32'h0000_0006, 1, 0);
    acc(1, `CRIT_SEL_ADDR, 32'h0001_0001, 1, 0);
    acc(1, `RUN_CTRL_ADDR, 32'h0000_0004, 1, 0);
    acc(1, `INPUT_SEL_ADDR, 32'h0000_0001, 1, 0);
    acc(1, `INPUT_SEL_ADDR, 32'h0000_0000, 0, 0);
    acc(1, `CMP_STATUS_ADDR, 32'h0000_0001, 1, 0);
    acc(1, 16'h0B22, 32'h0000_0000, 1, 0);
    acc(0, 16'h0B22, 0, 1, 0);
    acc(0, `CRIT_SEL_ADDR, 0, 0, 0);
    acc(0, `RUN_CTRL_ADDR, 0, 0, 0);
    acc(1, `THRESH_A_ADDR, VA, 0, 0);
    acc(1, `THRESH_B_ADDR, VB, 0, 0);
    acc(0, `THRESH_A_ADDR, 0, 0, VA);
    acc(0, `THRESH_B_ADDR, 0, 0, VB);
    acc(1, `RUN_CTRL_ADDR, 32'h0000_0001, 0, 0);
    for (int c = 0; c < 6; c++) begin
      acc(1, `CRIT_SEL_ADDR, 32'(c), 0, 0);
      for (int k = 0; k < 5; k++) begin
        sample(probe[k], hit(c, probe[k], VA, VB));
      end
    end
    // Swapped limits: only the extended forms sort them
    acc(1, `THRESH_A_ADDR, VB, 0, 0);
    acc(1, `THRESH_B_ADDR, VA, 0, 0);
    for (int c = 4; c < 6; c++) begin
      acc(1, `CRIT_SEL_ADDR, 32'(c), 0, 0);
      sample(probe[2], hit(c, probe[2], VB, VA));
      sample(probe[4], hit(c, probe[4], VB, VA));
    end
    acc(1, `CRIT_SEL_ADDR, 32'h0000_0000, 0, 0);
    sample(probe[0], 1'b0);
    acc(1, `RUN_CTRL_ADDR, 32'h0000_0000, 0, 0);
    sample(probe[4], 1'b0);
    acc(1, `RUN_CTRL_ADDR, 32'h0000_0003, 0, 0);
    forced(1'b1);
    sample(probe[0], 1'b1);
    acc(1, `RUN_CTRL_ADDR, 32'h0000_0002, 0, 0);
    forced(1'b0);
    sample(probe[4], 1'b0);
    acc(1, `RUN_CTRL_ADDR, 32'h0000_0001, 0, 0);
    sample(probe[4], 1'b1);
    acc(0, `CMP_STATUS_ADDR, 0, 0, 32'h0000_0001);
    final_report();
  end
endmodule : tb

// File: verilog/pos_cmp_map.svh
// Address map, reset values and field layout of the position compare channel
`ifndef POS_CMP_MAP_SVH
`define POS_CMP_MAP_SVH

// Parameter addresses as seen on the fieldbus parameter port
`define RUN_CTRL_ADDR      16'h0B18
`define CRIT_SEL_ADDR      16'h0B1C
`define INPUT_SEL_ADDR     16'h0B20
`define THRESH_A_ADDR      16'h0B24
`define THRESH_B_ADDR      16'h0B26
`define CMP_STATUS_ADDR    16'h0B80

// Reset values
`define RUN_CTRL_RST       16'h0000
`define CRIT_SEL_RST       16'h0000
`define INPUT_SEL_RST      16'h0000
`define THRESH_A_RST       32'h0000_0000
`define THRESH_B_RST       32'h0000_0000
`define CMP_STATUS_RST     1'b0

// Field layout
`define FIELD16_MSB        15
`define STATUS_BIT_POS     0

`endif

// File: verilog/pos_cmp_pkg.sv
// Types shared by the position compare channel files
package pos_cmp_pkg;

  typedef enum logic [15:0] {
    CRIT_GE_A    = 16'h0000,
    CRIT_LE_A    = 16'h0001,
    CRIT_IN_BAS  = 16'h0002,
    CRIT_OUT_BAS = 16'h0003,
    CRIT_IN_EXT  = 16'h0004,
    CRIT_OUT_EXT = 16'h0005
  } criterion_e;

  typedef enum logic [15:0] {
    RUN_OFF_KEEP = 16'h0000,
    RUN_ON       = 16'h0001,
    RUN_OFF_CLR  = 16'h0002,
    RUN_OFF_SET  = 16'h0003
  } run_mode_e;

  typedef enum logic [15:0] {
    SRC_ENC1 = 16'h0000
  } source_e;

  typedef struct packed {
    logic               valid;
    logic signed [31:0] value;
  } pos_sample_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } par_req_s;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } par_rsp_s;

endpackage : pos_cmp_pkg

// File: verilog/position_compare_channel.sv
// Position compare channel: parameter port, comparator and status bit
//
// Overview of operation
// - criterion 0 sets status when position is at or above A.
// - criterion 1 sets status when position is at or below A.
// - criterion 2 sets status when position lies in A..B, limits inside.
// - criterion 3 sets status when position lies outside A..B, limits not outside.
// - criterion 4 is the inside test, extended form.
// - criterion 5 is outside test, extended; field takes 0..5, resets to 0.
// - run field 0 stops comparing and holds the status bit; reset value.
// - run field 1 keeps the status bit following the criterion.
// - run field 2 stops comparing and clears the status bit.
// - run field 3 stops comparing and sets status; above 3 is refused.
// - source field takes only 0, the first encoder position.
// - value A is a signed 32-bit read/write word, reset zero.
// - value B is a signed 32-bit read/write word, reset zero.
// - criterion, source and run writes act at once, no commit needed.
`timescale 1ns/100ps
`include "pos_cmp_map.svh"
module position_compare_channel
  import pos_cmp_pkg::*;
#(
  parameter int POS_W = 32
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire par_req_s    i_par,
  output par_rsp_s         o_par,
  input  wire pos_sample_s i_pos,
  output logic             o_status
);

  //////////////////////////////////////////////////////////////////////////////
  // Parameter registers

  run_mode_e           run_r;
  run_mode_e           run_nxt;
  criterion_e          crit_r;
  criterion_e          crit_nxt;
  source_e             src_r;
  source_e             src_nxt;
  logic signed [31:0]  a_r;
  logic signed [31:0]  a_nxt;
  logic signed [31:0]  b_r;
  logic signed [31:0]  b_nxt;
  par_rsp_s            rsp_r;
  par_rsp_s            rsp_nxt;

  // A 16-bit field only accepts values with a clear upper half up to its max
  function automatic logic field_ok(input logic [31:0] d, input logic [15:0] max);
    field_ok = (d[31:16] == 16'h0000) && (d[15:0] <= max);
  endfunction : field_ok

  always_comb begin
    run_nxt  = run_r;
    crit_nxt = crit_r;
    src_nxt  = src_r;
    a_nxt    = a_r;
    b_nxt    = b_r;
    rsp_nxt  = '0;
    if (i_par.wr) begin
      rsp_nxt.ack = 1'b1;
      case (i_par.addr)
        `RUN_CTRL_ADDR: begin
          if (field_ok(i_par.wdata, RUN_OFF_SET)) begin
            run_nxt = run_mode_e'(i_par.wdata[`FIELD16_MSB:0]);
          end else begin
            rsp_nxt.err = 1'b1;
          end
        end
        `CRIT_SEL_ADDR: begin
          if (field_ok(i_par.wdata, CRIT_OUT_EXT)) begin
            crit_nxt = criterion_e'(i_par.wdata[`FIELD16_MSB:0]);
          end else begin
            rsp_nxt.err = 1'b1;
          end
        end
        `INPUT_SEL_ADDR: begin
          if (field_ok(i_par.wdata, SRC_ENC1)) begin
            src_nxt = source_e'(i_par.wdata[`FIELD16_MSB:0]);
          end else begin
            rsp_nxt.err = 1'b1;
          end
        end
        `THRESH_A_ADDR: a_nxt = i_par.wdata;
        `THRESH_B_ADDR: b_nxt = i_par.wdata;
        default:        rsp_nxt.err = 1'b1;
      endcase
    end else if (i_par.rd) begin
      rsp_nxt.ack = 1'b1;
      case (i_par.addr)
        `RUN_CTRL_ADDR:   rsp_nxt.rdata = {16'h0000, run_r};
        `CRIT_SEL_ADDR:   rsp_nxt.rdata = {16'h0000, crit_r};
        `INPUT_SEL_ADDR:  rsp_nxt.rdata = {16'h0000, src_r};
        `THRESH_A_ADDR:   rsp_nxt.rdata = a_r;
        `THRESH_B_ADDR:   rsp_nxt.rdata = b_r;
        `CMP_STATUS_ADDR: rsp_nxt.rdata[`STATUS_BIT_POS] = o_status;
        default:          rsp_nxt.err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      run_r  <= run_mode_e'(`RUN_CTRL_RST);
      crit_r <= criterion_e'(`CRIT_SEL_RST);
      src_r  <= source_e'(`INPUT_SEL_RST);
      a_r    <= `THRESH_A_RST;
      b_r    <= `THRESH_B_RST;
      rsp_r  <= '0;
    end else begin
      run_r  <= run_nxt;
      crit_r <= crit_nxt;
      src_r  <= src_nxt;
      a_r    <= a_nxt;
      b_r    <= b_nxt;
      rsp_r  <= rsp_nxt;
    end
  end

  assign o_par = rsp_r;

  //////////////////////////////////////////////////////////////////////////////
  // Comparator and status bit

  logic               hit;
  logic               sample_ok;
  logic               status_r;
  logic               status_nxt;

  range_comparator #(
    .W       (POS_W)
  ) u_cmp (
    .i_pos   (i_pos.value),
    .i_lim_a (a_r),
    .i_lim_b (b_r),
    .i_crit  (crit_r),
    .o_hit   (hit)
  );

  // Only the first encoder exists, so a legal source always passes the sample
  assign sample_ok = i_pos.valid && (src_r == SRC_ENC1);

  // Settings in force this cycle judge the sample; no shadow copies to commit
  always_comb begin
    status_nxt = status_r;
    unique case (run_r)
      RUN_OFF_KEEP: status_nxt = status_r;
      RUN_ON: begin
        if (sample_ok) begin
          status_nxt = hit;
        end
      end
      RUN_OFF_CLR:  status_nxt = 1'b0;
      RUN_OFF_SET:  status_nxt = 1'b1;
      default:      status_nxt = status_r;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status_r <= `CMP_STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign o_status = status_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  logic signed [31:0] lo_chk;
  logic signed [31:0] hi_chk;

  always_comb begin
    lo_chk = (a_r <= b_r) ? a_r : b_r;
    hi_chk = (a_r <= b_r) ? b_r : a_r;
  end

  // Separate model of the six criteria, so the sample check is not circular
  logic exp_hit;

  always_comb begin
    unique case (crit_r)
      CRIT_GE_A:    exp_hit = (i_pos.value >= a_r);
      CRIT_LE_A:    exp_hit = (i_pos.value <= a_r);
      CRIT_IN_BAS:  exp_hit = (i_pos.value >= a_r) && (i_pos.value <= b_r);
      CRIT_OUT_BAS: exp_hit = (i_pos.value < a_r) || (i_pos.value > b_r);
      CRIT_IN_EXT:  exp_hit = (i_pos.value >= lo_chk) && (i_pos.value <= hi_chk);
      CRIT_OUT_EXT: exp_hit = (i_pos.value < lo_chk) || (i_pos.value > hi_chk);
      default:      exp_hit = 1'b0;
    endcase
  end

  sequence judged(criterion_e c);
    run_r == RUN_ON && i_pos.valid && crit_r == c;
  endsequence

  sequence run_write(logic [15:0] v);
    i_par.wr && i_par.addr == `RUN_CTRL_ADDR && i_par.wdata == {16'h0000, v};
  endsequence

  sequence crit_write(logic [15:0] v);
    i_par.wr && !i_par.rd && i_par.addr == `CRIT_SEL_ADDR && i_par.wdata == {16'h0000, v};
  endsequence

  chk_ge_a_hit: assert property (
    judged(CRIT_GE_A) |=> o_status == ($past(i_pos.value) >= $past(a_r)))
    else $error("status wrong for at-or-above A");

  chk_le_a_hit: assert property (
    judged(CRIT_LE_A) |=> o_status == ($past(i_pos.value) <= $past(a_r)))
    else $error("status wrong for at-or-below A");

  chk_in_basic_hit: assert property (
    judged(CRIT_IN_BAS) |=>
      o_status == ($past(i_pos.value) >= $past(a_r) && $past(i_pos.value) <= $past(b_r)))
    else $error("status wrong for inside basic range");

  chk_out_basic_hit: assert property (
    judged(CRIT_OUT_BAS) |=>
      o_status == ($past(i_pos.value) < $past(a_r) || $past(i_pos.value) > $past(b_r)))
    else $error("status wrong for outside basic range");

  chk_in_ext_hit: assert property (
    judged(CRIT_IN_EXT) |=>
      o_status == ($past(i_pos.value) >= $past(lo_chk) && $past(i_pos.value) <= $past(hi_chk)))
    else $error("status wrong for inside extended range");

  chk_out_ext_hit: assert property (
    judged(CRIT_OUT_EXT) |=>
      o_status == ($past(i_pos.value) < $past(lo_chk) || $past(i_pos.value) > $past(hi_chk)))
    else $error("status wrong for outside extended range");

  chk_crit_bad_write: assert property (
    crit_write(16'h0006) |=> o_par.ack && o_par.err && $stable(crit_r))
    else $error("criterion 6 was not refused");

  chk_off_hold_status: assert property (
    (run_r == RUN_OFF_KEEP) [*2] |-> $stable(o_status))
    else $error("status moved while off-keep");

  chk_on_idle_hold: assert property (
    run_r == RUN_ON && !i_pos.valid |=> o_status == $past(o_status))
    else $error("status moved without a sample");

  chk_force_zero: assert property (
    run_write(16'h0002) |=> run_r == RUN_OFF_CLR ##1 !o_status)
    else $error("off-clear did not clear status");

  chk_force_one: assert property (
    run_write(16'h0003) |=> ##1 o_status)
    else $error("off-set did not set status");

  chk_clear_holds: assert property (
    run_r == RUN_OFF_CLR |=> !o_status)
    else $error("status not zero while off-clear");

  chk_set_holds: assert property (
    run_r == RUN_OFF_SET |=> o_status)
    else $error("status not one while off-set");

  chk_run_bad_write: assert property (
    run_write(16'h0004) |=> o_par.ack && o_par.err && $stable(run_r))
    else $error("run value 4 was not refused");

  chk_run_range: assert property (
    run_r <= RUN_OFF_SET)
    else $error("run field beyond 3");

  chk_source_fixed: assert property (
    src_r == SRC_ENC1)
    else $error("source field left 0");

  chk_source_bad_write: assert property (
    i_par.wr && i_par.addr == `INPUT_SEL_ADDR && i_par.wdata != 32'h0000_0000 |=> o_par.err)
    else $error("nonzero source was not refused");

  chk_a_store: assert property (
    i_par.wr && i_par.addr == `THRESH_A_ADDR |=> a_r == $past(i_par.wdata))
    else $error("value A not stored");

  chk_a_readback: assert property (
    !i_par.wr && i_par.rd && i_par.addr == `THRESH_A_ADDR |=> o_par.rdata == $past(a_r))
    else $error("value A not read back");

  chk_b_store: assert property (
    i_par.wr && i_par.addr == `THRESH_B_ADDR |=> b_r == $past(i_par.wdata))
    else $error("value B not stored");

  chk_b_readback: assert property (
    !i_par.wr && i_par.rd && i_par.addr == `THRESH_B_ADDR |=> o_par.rdata == $past(b_r))
    else $error("value B not read back");

  chk_crit_at_once: assert property (
    crit_write(16'h0001) |=> crit_r == CRIT_LE_A)
    else $error("criterion write not in force next cycle");

  chk_run_at_once: assert property (
    run_write(16'h0001) |=> run_r == RUN_ON)
    else $error("run write not in force next cycle");

  chk_sample_now: assert property (
    run_r == RUN_ON && i_pos.valid |=> o_status == $past(exp_hit))
    else $error("sample not judged with current settings");

endmodule : position_compare_channel

// File: verilog/range_comparator.sv
// Combinational position comparator for the six criteria
`timescale 1ns/100ps
module range_comparator
  import pos_cmp_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic signed [W-1:0] i_pos,
  input  wire logic signed [W-1:0] i_lim_a,
  input  wire logic signed [W-1:0] i_lim_b,
  input  wire criterion_e          i_crit,
  output logic                     o_hit
);

  logic signed [W-1:0] lo;
  logic signed [W-1:0] hi;

  // Extended form sorts the limits, so A above B still forms a range
  always_comb begin
    lo = (i_lim_a <= i_lim_b) ? i_lim_a : i_lim_b;
    hi = (i_lim_a <= i_lim_b) ? i_lim_b : i_lim_a;
  end

  always_comb begin
    unique case (i_crit)
      CRIT_GE_A:    o_hit = (i_pos >= i_lim_a);
      CRIT_LE_A:    o_hit = (i_pos <= i_lim_a);
      CRIT_IN_BAS:  o_hit = (i_pos >= i_lim_a) && (i_pos <= i_lim_b);
      CRIT_OUT_BAS: o_hit = (i_pos < i_lim_a) || (i_pos > i_lim_b);
      CRIT_IN_EXT:  o_hit = (i_pos >= lo) && (i_pos <= hi);
      CRIT_OUT_EXT: o_hit = (i_pos < lo) || (i_pos > hi);
      default:      o_hit = 1'b0;
    endcase
  end

endmodule : range_comparator
